// file: bench/pms_master_model.sv
`timescale 1ns/1ps
module pms_master_model (
  input  wire logic        mclk,
  input  wire logic        rstn,
  input  wire logic        stall,
  input  wire logic        tx_valid,
  input  wire logic [7:0]  tx_data,
  output logic             tx_ready,
  input  wire logic        par_rd,
  input  wire logic [15:0] par_rd_index,
  input  wire logic [7:0]  par_rd_sub,
  output logic [31:0]      par_rd_data
);
  logic [7:0] got[$];
  logic       ph_ff;
  // Read data only valid with the request, otherwise a changing pattern
  assign par_rd_data = par_rd ? {par_rd_index[7:0], par_rd_sub, par_rd_index[15:8], 8'ha5}
                              : {32{ph_ff}};
  // Slow sink: takes a byte every other cycle
  assign tx_ready = !stall && ph_ff;
  always @(posedge mclk)
  begin
    ph_ff <= rstn ? !ph_ff : 1'b0;
    if (rstn && tx_valid && tx_ready)
      got.push_back(tx_data);
  end
endmodule // pms_master_model

// file: bench/pms_pdo_map_checker.sv
`timescale 1ns/1ps
module pms_pdo_map_checker (
  input wire logic        mclk,
  input wire logic        rstn,
  input wire logic [3:0]  al_state,
  input wire logic        cfg_wr,
  input wire logic [15:0] cfg_index,
  input wire logic [7:0]  cfg_sub,
  input wire logic [31:0] cfg_data,
  input wire logic        cfg_ack,
  input wire logic        cfg_err,
  input wire logic        par_wr,
  input wire logic [15:0] par_wr_index,
  input wire logic        par_is_drive,
  input wire logic [7:0]  par_menu,
  input wire logic        par_rd,
  input wire logic        tx_valid,
  input wire logic [7:0]  tx_data,
  input wire logic        tx_ready,
  input pms_pkg::pms_tx_e tx_phase,
  input wire logic [1:0]  link_up,
  input wire logic [1:0]  port_traffic,
  input wire logic [1:0]  led_green
);
  import pms_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rstn);
  wire map_obj = cfg_index[15:8] == 8'h16 || cfg_index[15:8] == 8'h1a;
  wire asg_obj = cfg_index == 16'h1c12 || cfg_index == 16'h1c13;
  sequence s_fetch;
    par_rd && tx_phase == PMS_TX_FETCH;
  endsequence
  sequence s_steady0;
    link_up[0] && !port_traffic[0];
  endsequence
  a_cfg_answer: assert property (
    (cfg_ack || cfg_err) |-> $past(cfg_wr) && !(cfg_ack && cfg_err))
    else $error("config answer without a write");
  a_map_limit: assert property (
    cfg_wr && map_obj && cfg_sub == 8'h00 && cfg_data > 32'h5 |=> cfg_err)
    else $error("map count above five accepted");
  a_asg_limit: assert property (
    cfg_wr && asg_obj && cfg_sub == 8'h00 && cfg_data > 32'h2 |=> cfg_err)
    else $error("assign count above two accepted");
  a_rx_offered: assert property (
    cfg_wr && al_state == 4'h2 && cfg_index == 16'h1c12 && cfg_sub inside {8'h1, 8'h2}
    && cfg_data inside {32'h1600, 32'h1601, 32'h1605, 32'h1615} |=> cfg_ack)
    else $error("offered receive object refused");
  a_wr_only_op: assert property (
    par_wr |-> $past(al_state) == 4'h8)
    else $error("parameter written outside operational");
  a_drive_menu: assert property (
    par_wr_index[15:8] == 8'h20 |-> par_is_drive && par_menu == par_wr_index[7:0])
    else $error("drive menu decode wrong");
  a_addr_fetch: assert property (
    par_rd |-> tx_phase == PMS_TX_FETCH && $past(tx_phase) == PMS_TX_ADDR)
    else $error("read request outside fetch");
  a_fetch_push: assert property (
    s_fetch |=> tx_phase == PMS_TX_PUSH)
    else $error("push does not follow fetch");
  a_tx_hold: assert property (
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
    else $error("transmit byte dropped or changed while stalled");
  a_led_off: assert property (
    !link_up[0] [*2] |=> !led_green[0])
    else $error("indicator lit without link");
  a_led_steady: assert property (
    s_steady0 [*2] |=> led_green[0])
    else $error("indicator not steady with link");
endmodule // pms_pdo_map_checker

// file: bench/pms_pdo_map_tb_top.sv
`timescale 1ns/1ps
module pms_pdo_map_tb_top;
  import pms_pkg::*;
  logic        mclk, rstn, cfg_wr, rx_sof, rx_valid, tx_start, stall;
  logic        cfg_ack, cfg_err, par_wr, par_wr_low, par_rd, tx_valid, tx_ready, par_is_drive;
  logic [1:0]  link_up, port_traffic, led_green;
  logic [3:0]  al_state;
  logic [7:0]  cfg_sub, rx_data, par_wr_sub, par_rd_sub, tx_data, par_menu;
  logic [11:0] rx_img_bits, tx_img_bits;
  logic [15:0] cfg_index, par_wr_index, par_rd_index;
  logic [31:0] cfg_data, par_wr_data, par_rd_data;
  pms_tx_e     tx_phase;
  logic [56:0] pw[$];
  logic [7:0]  exp_b[$];
  int          err_total, total_checks;

  pms_pdo_map #(.FLASH_HALF_CYC(8)) uut (
    .mclk, .rstn, .al_state, .cfg_wr, .cfg_index, .cfg_sub, .cfg_data, .cfg_ack, .cfg_err,
    .rx_sof, .rx_valid, .rx_data, .par_wr, .par_wr_index, .par_wr_sub, .par_wr_data,
    .par_wr_low, .tx_start, .par_rd, .par_rd_index, .par_rd_sub, .par_rd_data, .tx_valid,
    .tx_data, .tx_ready, .tx_phase, .rx_img_bits, .tx_img_bits, .par_is_drive, .par_menu,
    .link_up, .port_traffic, .led_green);
  pms_master_model pm (
    .mclk, .rstn, .stall, .tx_valid, .tx_data, .tx_ready, .par_rd, .par_rd_index,
    .par_rd_sub, .par_rd_data);

  initial
  begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  always @(posedge mclk)
    if (par_wr === 1'b1)
      pw.push_back({par_wr_index, par_wr_sub, par_wr_data, par_wr_low});

  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task conclude;
    if (err_total == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask

  task automatic set_state(input logic [3:0] s);
    @(posedge mclk);
    al_state <= s;
  endtask

  task automatic cfg(input logic [15:0] i, input logic [7:0] s, input logic [31:0] d,
                     input logic e);
    @(posedge mclk);
    cfg_wr <= 1'b1;
    cfg_index <= i;
    cfg_sub <= s;
    cfg_data <= d;
    @(posedge mclk);
    cfg_wr <= 1'b0;
    @(negedge mclk);
    chk("cfg answer", {e, !e}, {cfg_err, cfg_ack});
  endtask

  task automatic send(input logic [7:0] b[$]);
    @(posedge mclk);
    rx_sof <= 1'b1;
    foreach (b[k])
    begin
      @(posedge mclk);
      rx_sof <= 1'b0;
      rx_valid <= 1'b1;
      rx_data <= b[k];
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    settle(4);
  endtask

  task automatic exp_ent(input logic [15:0] i, input logic [7:0] s, input int nb);
    logic [31:0] w;
    w = {i[7:0], s, i[15:8], 8'ha5};
    for (int k = 0; k < nb; k++)
      exp_b.push_back(w[8*k +: 8]);
  endtask

  task automatic t_map;
    set_state(4'h2);
    cfg(16'h1600, 8'h01, 32'h60400010, 1'b0);
    cfg(16'h1600, 8'h02, 32'h00000010, 1'b0);
    cfg(16'h1600, 8'h03, 32'h20141520, 1'b0);
    cfg(16'h1600, 8'h00, 32'h3, 1'b0);
    cfg(16'h1c12, 8'h01, 32'h1600, 1'b0);
    cfg(16'h1c12, 8'h00, 32'h1, 1'b0);
    settle(2);
    chk("rx_img_bits", 64, rx_img_bits);
  endtask

  task automatic t_refuse;
    logic [15:0] rxo[4] = '{16'h1600, 16'h1601, 16'h1605, 16'h1615};
    logic [15:0] txo[5] = '{16'h1a00, 16'h1a01, 16'h1a02, 16'h1a05, 16'h1a15};
    cfg(16'h1600, 8'h00, 32'h6, 1'b1);
    cfg(16'h1600, 8'h06, 32'h60400010, 1'b1);
    cfg(16'h1600, 8'h04, 32'h6040000c, 1'b1);
    cfg(16'h1600, 8'h04, 32'h60400028, 1'b1);
    cfg(16'h1c12, 8'h00, 32'h3, 1'b1);
    cfg(16'h1c12, 8'h02, 32'h1a00, 1'b1);
    cfg(16'h1c13, 8'h01, 32'h1600, 1'b1);
    cfg(16'h1c12, 8'h02, 32'h1602, 1'b1);
    foreach (rxo[k])
      cfg(16'h1c12, 8'h02, {16'h0, rxo[k]}, 1'b0);
    foreach (txo[k])
      cfg(16'h1c13, 8'h02, {16'h0, txo[k]}, 1'b0);
    settle(2);
    chk("rx_img_bits", 64, rx_img_bits);
  endtask

  task automatic t_rx;
    cfg(16'h1615, 8'h01, 32'h20010108, 1'b0);
    cfg(16'h1615, 8'h00, 32'h1, 1'b0);
    cfg(16'h1c12, 8'h00, 32'h2, 1'b0);
    set_state(4'h8);
    send('{8'h34, 8'h12, 8'hee, 8'hff, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'h5a});
    chk("par_wr count", 3, pw.size());
    chk("par_menu", {1'b1, 8'h01}, {par_is_drive, par_menu});
    if (pw.size() == 3)
    begin
      chk("par_wr first", {16'h6040, 8'h00, 32'h1234, 1'b0}, pw[0]);
      chk("par_wr second", {16'h2014, 8'h15, 32'hd4c3b2a1, 1'b0}, pw[1]);
      chk("par_wr third", {16'h2001, 8'h01, 32'h5a, 1'b1}, pw[2]);
    end
    set_state(4'h4);
    send('{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08});
    chk("par_wr count", 3, pw.size());
  endtask

  task automatic t_tx;
    int n;
    set_state(4'h2);
    for (int k = 1; k <= 5; k++)
      cfg(16'h1a00, k[7:0], {16'h2000 + k[15:0], 16'h0120}, 1'b0);
    cfg(16'h1a00, 8'h00, 32'h5, 1'b0);
    cfg(16'h1a05, 8'h01, 32'h20121610, 1'b0);
    cfg(16'h1a05, 8'h02, 32'h20141620, 1'b0);
    cfg(16'h1a05, 8'h00, 32'h2, 1'b0);
    cfg(16'h1c13, 8'h01, 32'h1a00, 1'b0);
    cfg(16'h1c13, 8'h02, 32'h1a05, 1'b0);
    cfg(16'h1c13, 8'h00, 32'h2, 1'b0);
    settle(2);
    chk("tx_img_bits", 208, tx_img_bits);
    for (int k = 1; k <= 5; k++)
      exp_ent(16'h2000 + k[15:0], 8'h01, 4);
    exp_ent(16'h2012, 8'h16, 2);
    exp_ent(16'h2014, 8'h16, 4);
    set_state(4'h8);
    stall <= 1'b1;
    @(posedge mclk);
    tx_start <= 1'b1;
    @(posedge mclk);
    tx_start <= 1'b0;
    settle(60);
    chk("stalled phase", PMS_TX_PUSH, tx_phase);
    chk("bytes while stalled", 0, pm.got.size());
    @(posedge mclk);
    stall <= 1'b0;
    n = 0;
    while (pm.got.size() < exp_b.size() && n < 300)
    begin
      @(posedge mclk);
      n++;
    end
    settle(3);
    chk("tx byte count", exp_b.size(), pm.got.size());
    foreach (exp_b[k])
      if (k < pm.got.size())
        chk("tx byte", exp_b[k], pm.got[k]);
    chk("drained", {1'b0, PMS_TX_IDLE}, {tx_valid, tx_phase});
  endtask

  task automatic t_led;
    logic [1:0] seen;
    @(posedge mclk);
    link_up <= 2'b01;
    settle(3);
    chk("led_green", 2'b01, led_green);
    @(posedge mclk);
    port_traffic <= 2'b01;
    seen = 2'b00;
    repeat (40)
    begin
      @(negedge mclk);
      if (led_green[0] === 1'b1)
        seen[1] = 1'b1;
      else
        seen[0] = 1'b1;
    end
    chk("led flash", 2'b11, seen);
    chk("led idle port", 1'b0, led_green[1]);
    @(posedge mclk);
    link_up <= 2'b00;
    settle(3);
    chk("led_green", 2'b00, led_green);
  endtask

  initial
  begin
    repeat (20000) @(posedge mclk);
    err_total++;
    conclude;
  end

  initial
  begin
    rstn = 1'b0;
    al_state = 4'h1;
    cfg_wr = 1'b0;
    cfg_index = 16'h0;
    cfg_sub = 8'h0;
    cfg_data = 32'h0;
    rx_sof = 1'b0;
    rx_valid = 1'b0;
    rx_data = 8'h0;
    tx_start = 1'b0;
    stall = 1'b0;
    link_up = 2'b00;
    port_traffic = 2'b00;
    err_total = 0;
    total_checks = 0;
    repeat (6) @(posedge mclk);
    rstn <= 1'b1;
    settle(1);
    chk("idle outputs", {2'b00, 1'b0, PMS_TX_IDLE}, {led_green, cfg_ack, tx_phase});
    t_map;
    t_refuse;
    t_rx;
    t_tx;
    t_led;
    conclude;
  end
endmodule // pms_pdo_map_tb_top

bind pms_pdo_map pms_pdo_map_checker u_chk (
  .mclk, .rstn, .al_state, .cfg_wr, .cfg_index, .cfg_sub, .cfg_data, .cfg_ack, .cfg_err,
  .par_wr, .par_wr_index, .par_is_drive, .par_menu, .par_rd, .tx_valid, .tx_data,
  .tx_ready, .tx_phase, .link_up, .port_traffic, .led_green);

// file: logic/pms_fifo.sv
`timescale 1ns/1ps
module pms_fifo #(
  parameter int W = 8,
  parameter int D = 16
) (
  input wire logic  mclk,
  input wire logic  rstn,
  pms_stream_if.snk wr,
  pms_stream_if.src rd
);
  import pms_pkg::*;

  localparam int AW = $clog2(D);

  logic [W-1:0] mem_ff [D];
  logic [AW:0]  wr_ptr_ff;
  logic [AW:0]  rd_ptr_ff;

  wire          full  = (wr_ptr_ff[AW] != rd_ptr_ff[AW]) &&
                        (wr_ptr_ff[AW-1:0] == rd_ptr_ff[AW-1:0]);
  wire          empty = (wr_ptr_ff == rd_ptr_ff);
  wire          do_wr = wr.valid && !full;
  wire          do_rd = rd.ready && !empty;

  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data  = mem_ff[rd_ptr_ff[AW-1:0]];

  always_ff @(posedge mclk)
  begin
    if (do_wr)
      mem_ff[wr_ptr_ff[AW-1:0]] <= wr.data;
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
    end
    else
    begin
      if (do_wr)
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      if (do_rd)
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
    end
  end
endmodule // pms_fifo

// file: logic/pms_params.svh
`ifndef PMS_PARAMS_SVH
`define PMS_PARAMS_SVH

// Clock and indicator timing
`define PMS_CLK_PERIOD_NS   50
`define PMS_FLASH_HALF_MS   100
`define PMS_FLASH_HALF_CYC  ((`PMS_FLASH_HALF_MS * 1000000) / `PMS_CLK_PERIOD_NS)

// Mapping entry field positions
`define PMS_LEN_LSB         0
`define PMS_SUB_LSB         8
`define PMS_IDX_LSB         16

// Object indices
`define PMS_RXASG_IDX       16'h1c12
`define PMS_TXASG_IDX       16'h1c13
`define PMS_PAR_BASE        16'h2000
`define PMS_PAR_END         16'h6000
`define PMS_RXMAP_1         16'h1600
`define PMS_RXMAP_2         16'h1601
`define PMS_RXMAP_6         16'h1605
`define PMS_RXMAP_22        16'h1615
`define PMS_TXMAP_1         16'h1a00
`define PMS_TXMAP_2         16'h1a01
`define PMS_TXMAP_3         16'h1a02
`define PMS_TXMAP_6         16'h1a05
`define PMS_TXMAP_22        16'h1a15

// Table sizes and limits
`define PMS_NSLOT           9
`define PMS_NRX_SLOT        4'h4
`define PMS_MAX_ENT         5
`define PMS_MAX_ENT_W       3'h5
`define PMS_MAX_PDO         2'h2
`define PMS_MAX_BITS        8'h20

// Slave state codes
`define PMS_AL_INIT         4'h1
`define PMS_AL_PREOP        4'h2
`define PMS_AL_SAFEOP       4'h4
`define PMS_AL_OP           4'h8

// Transmit buffer shape
`define PMS_FIFO_W          8
`define PMS_FIFO_D          16

`endif

// file: logic/pms_pdo_map.sv
`timescale 1ns/1ps
`include "pms_params.svh"
module pms_pdo_map #(
  parameter int unsigned FLASH_HALF_CYC = `PMS_FLASH_HALF_CYC
) (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire logic [3:0]        al_state,
  input  wire logic              cfg_wr,
  input  wire logic [15:0]       cfg_index,
  input  wire logic [7:0]        cfg_sub,
  input  wire logic [31:0]       cfg_data,
  output logic                   cfg_ack,
  output logic                   cfg_err,
  input  wire logic              rx_sof,
  input  wire logic              rx_valid,
  input  wire logic [7:0]        rx_data,
  output logic                   par_wr,
  output logic [15:0]            par_wr_index,
  output logic [7:0]             par_wr_sub,
  output logic [31:0]            par_wr_data,
  output logic                   par_wr_low,
  input  wire logic              tx_start,
  output logic                   par_rd,
  output logic [15:0]            par_rd_index,
  output logic [7:0]             par_rd_sub,
  input  wire logic [31:0]       par_rd_data,
  output logic                   tx_valid,
  output logic [7:0]             tx_data,
  input  wire logic              tx_ready,
  output pms_pkg::pms_tx_e       tx_phase,
  output logic [11:0]            rx_img_bits,
  output logic [11:0]            tx_img_bits,
  output logic                   par_is_drive,
  output logic [7:0]             par_menu,
  input  wire logic [1:0]        link_up,
  input  wire logic [1:0]        port_traffic,
  output logic [1:0]             led_green
);
  import pms_pkg::*;

  logic [2:0]  map_cnt_ff [`PMS_NSLOT];
  logic [31:0] map_ent_ff [`PMS_NSLOT][`PMS_MAX_ENT];
  logic [1:0]  asg_cnt_ff [2];
  pms_slot_t   asg_slot_ff [2][2];

  function automatic logic [4:0] slot_of(input logic [15:0] idx);
    case (idx)
      `PMS_RXMAP_1:  slot_of = 5'h10;
      `PMS_RXMAP_2:  slot_of = 5'h11;
      `PMS_RXMAP_6:  slot_of = 5'h12;
      `PMS_RXMAP_22: slot_of = 5'h13;
      `PMS_TXMAP_1:  slot_of = 5'h14;
      `PMS_TXMAP_2:  slot_of = 5'h15;
      `PMS_TXMAP_3:  slot_of = 5'h16;
      `PMS_TXMAP_6:  slot_of = 5'h17;
      `PMS_TXMAP_22: slot_of = 5'h18;
      default:       slot_of = 5'h00;
    endcase
  endfunction

  function automatic logic [2:0] nbytes(input logic [7:0] len);
    nbytes = 3'((9'(len) + 9'h7) >> 3);
  endfunction

  // Returns {done, obj, ent} for the entry after the current one
  function automatic logic [4:0] walk_next(input logic obj, input logic [2:0] ent,
                                           input logic [2:0] cnt, input logic [1:0] nobj);
    if ((4'(ent) + 4'h1) < 4'(cnt))
      walk_next = {1'b0, obj, ent + 3'h1};
    else if ((2'(obj) + 2'h1) < nobj)
      walk_next = {1'b0, 1'b1, 3'h0};
    else
      walk_next = {1'b1, obj, 3'h0};
  endfunction

  // Configuration decode; every setting arrives over the network
  wire [4:0]  cfg_slot   = slot_of(cfg_index);
  wire [4:0]  tgt_slot   = slot_of(cfg_data[15:0]);
  wire        is_map     = cfg_slot[4];
  wire        is_rxasg   = (cfg_index == `PMS_RXASG_IDX);
  wire        is_txasg   = (cfg_index == `PMS_TXASG_IDX);
  wire        locked     = (al_state == `PMS_AL_SAFEOP) || (al_state == `PMS_AL_OP);
  wire [7:0]  cfg_len    = cfg_data[`PMS_LEN_LSB +: 8];
  wire        cfg_gap    = (cfg_data[`PMS_IDX_LSB +: 16] == 16'h0) &&
                           (cfg_data[`PMS_SUB_LSB +: 8] == 8'h0);
  wire        len_ok     = cfg_gap ? (cfg_len <= `PMS_MAX_BITS) :
                           (cfg_len != 8'h0) && (cfg_len[2:0] == 3'h0) &&
                           (cfg_len <= `PMS_MAX_BITS);
  wire        map_cnt_ok = (cfg_sub == 8'h0) && (cfg_data[31:3] == 29'h0) &&
                           (cfg_data[2:0] <= `PMS_MAX_ENT_W);
  wire        map_ent_ok = (cfg_sub != 8'h0) && (cfg_sub <= 8'(`PMS_MAX_ENT)) &&
                           len_ok;
  wire        asg_cnt_ok = (cfg_sub == 8'h0) && (cfg_data[31:2] == 30'h0) &&
                           (cfg_data[1:0] <= `PMS_MAX_PDO);
  wire        tgt_is_rx  = tgt_slot[3:0] < `PMS_NRX_SLOT;
  wire        asg_ent_ok = (cfg_sub == 8'h1 || cfg_sub == 8'h2) &&
                           (cfg_data[31:16] == 16'h0) && tgt_slot[4] &&
                           (is_rxasg == tgt_is_rx);
  wire        is_asg     = is_rxasg || is_txasg;
  wire        cfg_ok     = !locked && ((is_map && (map_cnt_ok || map_ent_ok)) ||
                                       (is_asg && (asg_cnt_ok || asg_ent_ok)));
  wire        asg_dir    = is_txasg;
  wire        asg_pos    = (cfg_sub == 8'h2);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      for (int s = 0; s < `PMS_NSLOT; s++)
      begin
        map_cnt_ff[s] <= 3'h0;
        for (int e = 0; e < `PMS_MAX_ENT; e++)
          map_ent_ff[s][e] <= 32'h0;
      end
      for (int d = 0; d < 2; d++)
      begin
        asg_cnt_ff[d]     <= 2'h0;
        asg_slot_ff[d][0] <= 4'h0;
        asg_slot_ff[d][1] <= 4'h0;
      end
    end
    else if (cfg_wr && cfg_ok)
    begin
      if (is_map && map_cnt_ok)
        map_cnt_ff[cfg_slot[3:0]] <= cfg_data[2:0];
      else if (is_map)
        map_ent_ff[cfg_slot[3:0]][3'(cfg_sub - 8'h1)] <= cfg_data;
      else if (asg_cnt_ok)
        asg_cnt_ff[asg_dir] <= cfg_data[1:0];
      else
        asg_slot_ff[asg_dir][asg_pos] <= tgt_slot[3:0];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      cfg_ack <= 1'b0;
      cfg_err <= 1'b0;
    end
    else
    begin
      cfg_ack <= cfg_wr && cfg_ok;
      cfg_err <= cfg_wr && !cfg_ok;
    end
  end

  // Receive path: master to device
  logic        rx_act_ff;
  logic        rx_obj_ff;
  logic [2:0]  rx_ent_ff;
  logic [2:0]  rx_byte_ff;
  logic [31:0] rx_acc_ff;

  wire pms_slot_t rx_slot  = asg_slot_ff[0][rx_obj_ff];
  wire        rx_live      = rx_ent_ff < map_cnt_ff[rx_slot];
  wire pms_ent_s rx_ent    = map_ent_ff[rx_slot][rx_ent_ff];
  wire [2:0]  rx_nb        = rx_live ? nbytes(rx_ent.len) : 3'h0;
  wire        rx_gap       = (rx_ent.idx == 16'h0) && (rx_ent.sub == 8'h0);
  wire [4:0]  rx_nxt       = walk_next(rx_obj_ff, rx_ent_ff, map_cnt_ff[rx_slot],
                                       asg_cnt_ff[0]);
  wire [31:0] rx_word      = rx_acc_ff | (32'(rx_data) << {rx_byte_ff, 3'h0});
  wire        rx_last      = (rx_byte_ff + 3'h1) == rx_nb;
  wire        is_op        = (al_state == `PMS_AL_OP);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rx_act_ff  <= 1'b0;
      rx_obj_ff  <= 1'b0;
      rx_ent_ff  <= 3'h0;
      rx_byte_ff <= 3'h0;
      rx_acc_ff  <= 32'h0;
    end
    else if (rx_sof)
    begin
      rx_act_ff  <= asg_cnt_ff[0] != 2'h0;
      rx_obj_ff  <= 1'b0;
      rx_ent_ff  <= 3'h0;
      rx_byte_ff <= 3'h0;
      rx_acc_ff  <= 32'h0;
    end
    else if (rx_act_ff && (rx_nb == 3'h0 || (rx_valid && rx_last)))
    begin
      rx_act_ff  <= !rx_nxt[4];
      rx_obj_ff  <= rx_nxt[3];
      rx_ent_ff  <= rx_nxt[2:0];
      rx_byte_ff <= 3'h0;
      rx_acc_ff  <= 32'h0;
    end
    else if (rx_act_ff && rx_valid)
    begin
      rx_byte_ff <= rx_byte_ff + 3'h1;
      rx_acc_ff  <= rx_word;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      par_wr       <= 1'b0;
      par_wr_index <= 16'h0;
      par_wr_sub   <= 8'h0;
      par_wr_data  <= 32'h0;
      par_wr_low   <= 1'b0;
    end
    else
    begin
      par_wr <= rx_act_ff && rx_nb != 3'h0 && rx_valid && rx_last &&
                !rx_gap && is_op;
      if (rx_act_ff && rx_valid && rx_last)
      begin
        par_wr_index <= rx_ent.idx;
        par_wr_sub   <= rx_ent.sub;
        par_wr_data  <= rx_word;
        par_wr_low   <= rx_obj_ff;
      end
    end
  end

  // Transmit path: device to master through the buffer
  pms_stream_if #(.W(`PMS_FIFO_W)) push_if ();
  pms_stream_if #(.W(`PMS_FIFO_W)) pop_if ();

  logic        tx_obj_ff;
  logic [2:0]  tx_ent_ff;
  logic [2:0]  tx_byte_ff;
  logic [31:0] tx_word_ff;
  logic        tx_gap_ff;

  wire pms_slot_t tx_slot  = asg_slot_ff[1][tx_obj_ff];
  wire        tx_live      = tx_ent_ff < map_cnt_ff[tx_slot];
  wire pms_ent_s tx_ent    = map_ent_ff[tx_slot][tx_ent_ff];
  wire [2:0]  tx_nb        = tx_live ? nbytes(tx_ent.len) : 3'h0;
  wire        tx_gap       = (tx_ent.idx == 16'h0) && (tx_ent.sub == 8'h0);
  wire [4:0]  tx_nxt       = walk_next(tx_obj_ff, tx_ent_ff, map_cnt_ff[tx_slot],
                                       asg_cnt_ff[1]);
  wire        tx_ok_state  = (al_state == `PMS_AL_SAFEOP) || is_op;
  wire        tx_last      = (tx_byte_ff + 3'h1) == tx_nb;
  wire        tx_adv       = (tx_phase == PMS_TX_ADDR && tx_nb == 3'h0) ||
                             (tx_phase == PMS_TX_PUSH && push_if.ready && tx_last);

  assign push_if.valid = (tx_phase == PMS_TX_PUSH);
  assign push_if.data  = 8'(tx_word_ff >> {tx_byte_ff, 3'h0});
  assign pop_if.ready  = tx_ready;
  assign tx_valid      = pop_if.valid;
  assign tx_data       = pop_if.data;

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      tx_phase   <= PMS_TX_IDLE;
      tx_obj_ff  <= 1'b0;
      tx_ent_ff  <= 3'h0;
      tx_byte_ff <= 3'h0;
    end
    else
    begin
      unique case (tx_phase)
        PMS_TX_IDLE:
          if (tx_start && tx_ok_state && asg_cnt_ff[1] != 2'h0)
          begin
            tx_phase  <= PMS_TX_ADDR;
            tx_obj_ff <= 1'b0;
            tx_ent_ff <= 3'h0;
          end
        PMS_TX_ADDR:
          if (tx_nb != 3'h0)
            tx_phase <= PMS_TX_FETCH;
        PMS_TX_FETCH:
        begin
          tx_phase   <= PMS_TX_PUSH;
          tx_byte_ff <= 3'h0;
        end
        PMS_TX_PUSH:
          if (push_if.ready && !tx_last)
            tx_byte_ff <= tx_byte_ff + 3'h1;
      endcase
      if (tx_adv)
      begin
        tx_phase  <= tx_nxt[4] ? PMS_TX_IDLE : PMS_TX_ADDR;
        tx_obj_ff <= tx_nxt[3];
        tx_ent_ff <= tx_nxt[2:0];
      end
    end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      par_rd       <= 1'b0;
      par_rd_index <= 16'h0;
      par_rd_sub   <= 8'h0;
      tx_gap_ff    <= 1'b0;
      tx_word_ff   <= 32'h0;
    end
    else
    begin
      par_rd <= (tx_phase == PMS_TX_ADDR) && tx_nb != 3'h0 && !tx_gap;
      if (tx_phase == PMS_TX_ADDR)
      begin
        par_rd_index <= tx_ent.idx;
        par_rd_sub   <= tx_ent.sub;
        tx_gap_ff    <= tx_gap;
      end
      if (tx_phase == PMS_TX_FETCH)
        tx_word_ff <= tx_gap_ff ? 32'h0 : par_rd_data;
    end
  end

  pms_fifo #(.W(`PMS_FIFO_W), .D(`PMS_FIFO_D)) u_txbuf (
    .mclk (mclk),
    .rstn (rstn),
    .wr   (push_if),
    .rd   (pop_if)
  );

  // Parameter address split of the last completed receive entry, written or not
  assign par_is_drive = (par_wr_index >= `PMS_PAR_BASE) &&
                        (par_wr_index < `PMS_PAR_END);
  assign par_menu     = 8'(par_wr_index - `PMS_PAR_BASE);

  // Image lengths
  logic [11:0] rx_bits_sum;
  logic [11:0] tx_bits_sum;

  always_comb
  begin
    rx_bits_sum = 12'h0;
    tx_bits_sum = 12'h0;
    for (int o = 0; o < 2; o++)
      for (int e = 0; e < `PMS_MAX_ENT; e++)
      begin
        if (2'(o) < asg_cnt_ff[0] && 3'(e) < map_cnt_ff[asg_slot_ff[0][o]])
          rx_bits_sum = rx_bits_sum + 12'(map_ent_ff[asg_slot_ff[0][o]][e][7:0]);
        if (2'(o) < asg_cnt_ff[1] && 3'(e) < map_cnt_ff[asg_slot_ff[1][o]])
          tx_bits_sum = tx_bits_sum + 12'(map_ent_ff[asg_slot_ff[1][o]][e][7:0]);
      end
  end

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      rx_img_bits <= 12'h0;
      tx_img_bits <= 12'h0;
    end
    else
    begin
      rx_img_bits <= rx_bits_sum;
      tx_img_bits <= tx_bits_sum;
    end
  end

  // Port indicators
  logic [21:0] flash_cnt_ff;
  logic        blink_ff;

  wire         cfg_loaded = (asg_cnt_ff[0] != 2'h0 || asg_cnt_ff[1] != 2'h0) &&
                            (al_state != `PMS_AL_INIT);

  always_ff @(posedge mclk)
  begin
    if (!rstn)
    begin
      flash_cnt_ff <= 22'h0;
      blink_ff     <= 1'b0;
      led_green    <= 2'h0;
    end
    else
    begin
      flash_cnt_ff <= (flash_cnt_ff == 22'(FLASH_HALF_CYC - 1)) ? 22'h0 : flash_cnt_ff + 22'h1;
      if (flash_cnt_ff == 22'(FLASH_HALF_CYC - 1))
        blink_ff <= !blink_ff;
      for (int p = 0; p < 2; p++)
        led_green[p] <= link_up[p] &&
                        (!(port_traffic[p] && cfg_loaded) || blink_ff);
    end
  end
endmodule // pms_pdo_map

// file: logic/pms_pkg.sv
package pms_pkg;

  typedef enum logic [1:0] {PMS_TX_IDLE, PMS_TX_ADDR, PMS_TX_FETCH, PMS_TX_PUSH} pms_tx_e;

  typedef struct packed {
    logic [15:0] idx;
    logic [7:0]  sub;
    logic [7:0]  len;
  } pms_ent_s;

  typedef logic [3:0] pms_slot_t;

endpackage

// file: logic/pms_stream_if.sv
`timescale 1ns/1ps
interface pms_stream_if #(parameter int W = 8) ();
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface // pms_stream_if
